// ==== rtl/pll_switch_defs.vh ====
// Purpose: Shared constants for the reference switch and holdover control.
// Assumes: 12-bit register addresses and 8-bit register data.
// Notes:   Offsets are byte addresses of the serial host register space.
`ifndef PLL_SWITCH_DEFS_VH
`define PLL_SWITCH_DEFS_VH

// Register offsets.
`define OFF_FORCE_HOLD    12'h435
`define OFF_SWITCH_CTRL   12'h436
`define OFF_FAULT_MASKS   12'h437
`define OFF_RANK_LOW      12'h438
`define OFF_RANK_HIGH     12'h439
`define OFF_HITLESS_METH  12'h43a
`define OFF_THRESH_LOW    12'h43b
`define OFF_THRESH_HIGH   12'h43c
`define OFF_COARSE_LEN    12'h43d
`define OFF_COARSE_DLY    12'h43e
`define OFF_STATUS        12'h43f

// Field positions.
`define FORCE_HOLD_BIT    0
`define POLICY_LSB        0
`define HITLESS_EN_BIT    2
`define LOS_MASK_LSB      0
`define OOF_MASK_LSB      4
`define RANK_A_LSB        0
`define RANK_B_LSB        4
`define METHOD_LSB        0
`define MEAS_CTRL_LSB     2
`define HIST_VALID_BIT    1
`define WIDE_BW_BIT       2

// Switching policy codes.
`define POLICY_MANUAL     2'h0
`define POLICY_NONREV     2'h1
`define POLICY_REVERT     2'h2

// Reset values and the highest usable rank.
`define RST_POLICY        2'h0
`define RST_METHOD        2'h1
`define RST_MEAS_CTRL     2'h0
`define RST_RANK0         3'h1
`define RST_RANK1         3'h2
`define RST_RANK2         3'h3
`define RST_RANK3         3'h4
`define RST_THRESH        10'h000
`define RST_COARSE        5'h00
`define RANK_MAX          3'h4

`endif

// ==== rtl/rank_selector.v ====
// Purpose: Picks the best eligible input by rank for automatic switching.
// Assumes: Rank 1 is most important, 0 and 5 to 7 are never picked.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "pll_switch_defs.vh"

module rank_selector (
  // Candidate information
  input  wire [11:0] rank_i,
  input  wire [3:0]  valid_i,
  // Result
  output reg  [1:0]  best_o,
  output reg         found_o
);

  function [2:0] usable_rank;
    input [2:0] r;
    begin
      usable_rank = (r > `RANK_MAX) ? 3'h0 : r;
    end
  endfunction

  reg [2:0] best_rank;
  reg [2:0] r;
  integer   i;

  // Scanning downward with <= lets the lowest index win a tie.
  always @* begin
    best_o    = 2'h0;
    found_o   = 1'b0;
    best_rank = 3'h0;
    r         = 3'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      r = usable_rank(rank_i[i*3 +: 3]);
      if (valid_i[i] && (r != 3'h0) &&
          (!found_o || r <= best_rank)) begin
        best_o    = i[1:0];
        best_rank = r;
        found_o   = 1'b1;
      end
    end
  end

endmodule

// ==== rtl/bandwidth_ctrl.v ====
// Purpose: Chooses between the normal and the wide fastlock loop bandwidth.
// Assumes: Lock-lost flag comes from the lock detector of this loop.
// Notes:   Acquisition begins each time the loop starts tracking an input.
`timescale 1ns/10ps

module bandwidth_ctrl (
  // Clock and reset
  input  wire clk_i,
  input  wire resetn_i,
  // Loop state
  input  wire tracking_i,
  input  wire track_start_i,
  input  wire lock_lost_flag_i,
  // Fastlock controls
  input  wire fastlock_manual_i,
  input  wire fastlock_auto_i,
  // Status
  output reg  wide_bandwidth_active_o
);

  reg  acquiring;
  reg  next_acquiring;

  always @* begin
    next_acquiring = acquiring;
    if (track_start_i) begin
      next_acquiring = 1'b1;
    end else if (!tracking_i || !lock_lost_flag_i) begin
      next_acquiring = 1'b0;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acquiring               <= 1'b0;
      wide_bandwidth_active_o <= 1'b0;
    end else begin
      acquiring               <= next_acquiring;
      wide_bandwidth_active_o <= fastlock_manual_i |
                                 (fastlock_auto_i & next_acquiring);
    end
  end

endmodule

// ==== rtl/pll_input_switch_holdover_ctrl.v ====
// Purpose: Reference selection, holdover and hitless control of one loop.
// Assumes: Register strobes and fault inputs are synchronous to clk_i.
// Notes:   Loop filter, history averaging and fault detectors live outside.
//
// Summary of operation
// - Force-holdover bit 0 low keeps tracking; high forces holdover/freerun.
// - Forced exit goes to freerun without history, holdover with history.
// - Policy field selects manual, automatic non-revertive or revertive.
// - Hitless enable bit 2 turns phase buildout on for input changes.
// - Per-input signal-loss mask bits drop that fault from automatic-mode validity only.
// - Per-input frequency-offset mask bits drop that fault from automatic-mode validity only.
// - Each input has a three-bit rank, two per byte at bits 2:0 and 6:4.
// - Automatic mode picks the valid input of rank 1 to 4 with best rank; non-revertive first keeps a usable current input.
// - Rank zero is never auto-picked but remains manually selectable.
// - Equal winning ranks resolve to the lowest-numbered input.
// - Ten-bit phase threshold spans the low byte and bits 9:8 next.
// - Five-bit coarse measurement length is held in its own register.
// - Five-bit coarse measurement delay is held in its own register.
// - History-valid status bit 1 tells holdover from freerun on failure.
// - Status bit 2 shows when the wide fastlock bandwidth is in use.
// - History stops on failure or switch, clears when tracking resumes.
// - Auto fastlock widens bandwidth while acquiring until lock is seen.
`timescale 1ns/10ps
`include "pll_switch_defs.vh"

module pll_input_switch_holdover_ctrl (
  // Clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // Register access
  input  wire [11:0] reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_write_i,
  input  wire        reg_read_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         reg_rvalid_o,
  // Reference inputs
  input  wire [3:0]  signal_absent_fault_i,
  input  wire [3:0]  frequency_offset_fault_i,
  input  wire [1:0]  manual_select_i,
  // Loop feedback
  input  wire        lock_lost_flag_i,
  input  wire        history_ready_i,
  input  wire        fastlock_manual_i,
  input  wire        fastlock_auto_i,
  // Loop control
  output reg  [1:0]  selected_input_o,
  output reg         tracking_o,
  output reg         holdover_o,
  output reg         freerun_o,
  output reg         history_accumulate_o,
  output reg         history_clear_o,
  output wire        wide_bandwidth_active_o,
  // Hitless switching parameters
  output reg         hitless_enable_o,
  output reg  [1:0]  hitless_method_o,
  output reg  [1:0]  phase_measure_ctrl_o,
  output reg  [9:0]  phase_measure_threshold_o,
  output reg  [4:0]  coarse_measure_length_o,
  output reg  [4:0]  coarse_measure_delay_o
);

  // One-hot loop states.
  localparam [2:0] ST_TRACK = 3'h1;
  localparam [2:0] ST_HOLD  = 3'h2;
  localparam [2:0] ST_FREE  = 3'h4;

  // Control registers.
  reg        force_holdover;
  reg [1:0]  switching_policy;
  reg [3:0]  signal_absent_mask;
  reg [3:0]  freq_offset_mask;
  reg [2:0]  input0_rank;
  reg [2:0]  input1_rank;
  reg [2:0]  input2_rank;
  reg [2:0]  input3_rank;
  reg        history_valid_status;

  // Loop state.
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [1:0]  next_select;
  reg        next_good;
  reg        next_hist_valid;
  reg        track_start;

  wire [3:0]  raw_ok;
  wire [3:0]  auto_valid;
  wire [11:0] rank_vec;
  wire [3:0]  rank_nonzero;
  wire [1:0]  best_input;
  wire        best_found;
  wire        keep_current;
  wire        write_hit;

  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  function rank_usable;
    input [2:0] r;
    begin
      rank_usable = (r != 3'h0) && (r <= `RANK_MAX);
    end
  endfunction

  assign write_hit = reg_write_i;

  // Fault qualification for the manual and the automatic selector.
  assign raw_ok     = ~(signal_absent_fault_i | frequency_offset_fault_i);
  assign auto_valid = ~((signal_absent_fault_i & ~signal_absent_mask) |
                        (frequency_offset_fault_i & ~freq_offset_mask));

  assign rank_vec = {input3_rank, input2_rank, input1_rank, input0_rank};
  assign rank_nonzero = {rank_usable(input3_rank), rank_usable(input2_rank),
                         rank_usable(input1_rank), rank_usable(input0_rank)};

  rank_selector u_rank_selector (
    .rank_i  (rank_vec),
    .valid_i (auto_valid),
    .best_o  (best_input),
    .found_o (best_found)
  );

  // Non-revertive mode sticks with a current input that is still usable.
  assign keep_current = (switching_policy == `POLICY_NONREV) &&
                        auto_valid[selected_input_o] &&
                        rank_nonzero[selected_input_o];

  // Input choice and whether the chosen input can be tracked.
  always @* begin
    next_select = selected_input_o;
    next_good   = 1'b0;
    case (switching_policy)
      `POLICY_NONREV, `POLICY_REVERT: begin
        if (keep_current) begin
          next_good = 1'b1;
        end else if (best_found) begin
          next_select = best_input;
          next_good   = 1'b1;
        end
      end
      default: begin
        next_select = manual_select_i;
        next_good   = raw_ok[manual_select_i];
      end
    endcase
  end

  // Loop state: an input switch passes one cycle outside tracking so
  // that the history stops and is cleared on the new input.
  always @* begin
    next_state = ST_TRACK;
    if (force_holdover || !next_good ||
        (state == ST_TRACK && next_select != selected_input_o)) begin
      next_state = history_valid_status ? ST_HOLD : ST_FREE;
    end
  end

  // History validity tracking.
  always @* begin
    next_hist_valid = history_valid_status;
    track_start     = 1'b0;
    case (state)
      ST_TRACK: begin
        if (next_state == ST_TRACK && history_ready_i) begin
          next_hist_valid = 1'b1;
        end
      end
      ST_HOLD, ST_FREE: begin
        if (next_state == ST_TRACK) begin
          next_hist_valid = 1'b0;
          track_start     = 1'b1;
        end
      end
      default: begin
        next_hist_valid = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state                <= ST_FREE;
      selected_input_o     <= 2'h0;
      tracking_o           <= 1'b0;
      holdover_o           <= 1'b0;
      freerun_o            <= 1'b1;
      history_valid_status <= 1'b0;
      history_accumulate_o <= 1'b0;
      history_clear_o      <= 1'b0;
    end else begin
      state                <= next_state;
      selected_input_o     <= next_select;
      tracking_o           <= (next_state == ST_TRACK);
      holdover_o           <= (next_state == ST_HOLD);
      freerun_o            <= (next_state == ST_FREE);
      history_valid_status <= next_hist_valid;
      history_accumulate_o <= (next_state == ST_TRACK);
      history_clear_o      <= track_start;
    end
  end

  bandwidth_ctrl u_bandwidth_ctrl (
    .clk_i                   (clk_i),
    .resetn_i                (resetn_i),
    .tracking_i              (state == ST_TRACK),
    .track_start_i           (track_start),
    .lock_lost_flag_i        (lock_lost_flag_i),
    .fastlock_manual_i       (fastlock_manual_i),
    .fastlock_auto_i         (fastlock_auto_i),
    .wide_bandwidth_active_o (wide_bandwidth_active_o)
  );

  // Register writes.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      force_holdover            <= 1'b0;
      switching_policy          <= `RST_POLICY;
      hitless_enable_o          <= 1'b0;
      signal_absent_mask        <= 4'h0;
      freq_offset_mask          <= 4'h0;
      input0_rank               <= `RST_RANK0;
      input1_rank               <= `RST_RANK1;
      input2_rank               <= `RST_RANK2;
      input3_rank               <= `RST_RANK3;
      hitless_method_o          <= `RST_METHOD;
      phase_measure_ctrl_o      <= `RST_MEAS_CTRL;
      phase_measure_threshold_o <= `RST_THRESH;
      coarse_measure_length_o   <= `RST_COARSE;
      coarse_measure_delay_o    <= `RST_COARSE;
    end else if (write_hit) begin
      if (is_addr(reg_addr_i, `OFF_FORCE_HOLD)) begin
        force_holdover <= reg_wdata_i[`FORCE_HOLD_BIT];
      end
      if (is_addr(reg_addr_i, `OFF_SWITCH_CTRL)) begin
        switching_policy <= reg_wdata_i[`POLICY_LSB +: 2];
        hitless_enable_o <= reg_wdata_i[`HITLESS_EN_BIT];
      end
      if (is_addr(reg_addr_i, `OFF_FAULT_MASKS)) begin
        signal_absent_mask <= reg_wdata_i[`LOS_MASK_LSB +: 4];
        freq_offset_mask   <= reg_wdata_i[`OOF_MASK_LSB +: 4];
      end
      if (is_addr(reg_addr_i, `OFF_RANK_LOW)) begin
        input0_rank <= reg_wdata_i[`RANK_A_LSB +: 3];
        input1_rank <= reg_wdata_i[`RANK_B_LSB +: 3];
      end
      if (is_addr(reg_addr_i, `OFF_RANK_HIGH)) begin
        input2_rank <= reg_wdata_i[`RANK_A_LSB +: 3];
        input3_rank <= reg_wdata_i[`RANK_B_LSB +: 3];
      end
      if (is_addr(reg_addr_i, `OFF_HITLESS_METH)) begin
        hitless_method_o     <= reg_wdata_i[`METHOD_LSB +: 2];
        phase_measure_ctrl_o <= reg_wdata_i[`MEAS_CTRL_LSB +: 2];
      end
      if (is_addr(reg_addr_i, `OFF_THRESH_LOW)) begin
        phase_measure_threshold_o[7:0] <= reg_wdata_i;
      end
      if (is_addr(reg_addr_i, `OFF_THRESH_HIGH)) begin
        phase_measure_threshold_o[9:8] <= reg_wdata_i[1:0];
      end
      if (is_addr(reg_addr_i, `OFF_COARSE_LEN)) begin
        coarse_measure_length_o <= reg_wdata_i[4:0];
      end
      if (is_addr(reg_addr_i, `OFF_COARSE_DLY)) begin
        coarse_measure_delay_o <= reg_wdata_i[4:0];
      end
    end
  end

  // Read multiplexer; unused bits and unmapped addresses read as zero.
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `OFF_FORCE_HOLD: begin
        next_rdata[`FORCE_HOLD_BIT] = force_holdover;
      end
      `OFF_SWITCH_CTRL: begin
        next_rdata[`POLICY_LSB +: 2] = switching_policy;
        next_rdata[`HITLESS_EN_BIT]  = hitless_enable_o;
      end
      `OFF_FAULT_MASKS: begin
        next_rdata = {freq_offset_mask, signal_absent_mask};
      end
      `OFF_RANK_LOW: begin
        next_rdata = {1'b0, input1_rank, 1'b0, input0_rank};
      end
      `OFF_RANK_HIGH: begin
        next_rdata = {1'b0, input3_rank, 1'b0, input2_rank};
      end
      `OFF_HITLESS_METH: begin
        next_rdata = {4'h0, phase_measure_ctrl_o, hitless_method_o};
      end
      `OFF_THRESH_LOW: begin
        next_rdata = phase_measure_threshold_o[7:0];
      end
      `OFF_THRESH_HIGH: begin
        next_rdata = {6'h00, phase_measure_threshold_o[9:8]};
      end
      `OFF_COARSE_LEN: begin
        next_rdata = {3'h0, coarse_measure_length_o};
      end
      `OFF_COARSE_DLY: begin
        next_rdata = {3'h0, coarse_measure_delay_o};
      end
      `OFF_STATUS: begin
        next_rdata[`HIST_VALID_BIT] = history_valid_status;
        next_rdata[`WIDE_BW_BIT]    = wide_bandwidth_active_o;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_read_i;
      if (reg_read_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

endmodule

// ==== verif/ref_source_model.sv ====
// Purpose: Upstream reference sources with commanded fault states.
// Assumes: Fault states change only when the bench commands them.
// Notes:   Faults are registered, as a fault detector would present them.
`timescale 1ns/10ps
module ref_source_model (
  // Clock and reset
  input  wire       clk_i,
  input  wire       resetn_i,
  // Commanded faults
  input  wire [3:0] lose_cmd_i,
  input  wire [3:0] drift_cmd_i,
  // Fault indications
  output reg  [3:0] signal_absent_fault_o,
  output reg  [3:0] frequency_offset_fault_o
);
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      signal_absent_fault_o    <= 4'h0;
      frequency_offset_fault_o <= 4'h0;
    end else begin
      signal_absent_fault_o    <= lose_cmd_i;
      frequency_offset_fault_o <= drift_cmd_i;
    end
  end
endmodule

// ==== verif/pll_switch_chk.sv ====
// Purpose: Port-level checks of reference switch and holdover control.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to the design top from the testbench top file.
`timescale 1ns/10ps
module pll_switch_chk (
  // Clock and reset
  input wire        clk_i,
  input wire        resetn_i,
  // Register access
  input wire [11:0] reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_write_i,
  input wire        reg_read_i,
  input wire [7:0]  reg_rdata_o,
  input wire        reg_rvalid_o,
  // Loop state and bandwidth
  input wire        tracking_o,
  input wire        holdover_o,
  input wire        freerun_o,
  input wire        history_accumulate_o,
  input wire        history_clear_o,
  input wire        wide_bandwidth_active_o,
  input wire        fastlock_manual_i,
  input wire        fastlock_auto_i,
  // Hitless parameters
  input wire        hitless_enable_o,
  input wire [9:0]  phase_measure_threshold_o,
  input wire [4:0]  coarse_measure_length_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_read_valid: assert property (
    reg_rvalid_o == $past(reg_read_i)) else $error("read valid misplaced");
  chk_status_read: assert property (
    reg_read_i && reg_addr_i == 12'h43f |=>
    reg_rdata_o[2] == $past(wide_bandwidth_active_o) &&
    reg_rdata_o[7:3] == 5'h00 && !reg_rdata_o[0])
    else $error("status read wrong");
  chk_state_onehot: assert property (
    $onehot({tracking_o, holdover_o, freerun_o})) else $error("state");
  chk_force_leaves: assert property (
    reg_write_i && reg_addr_i == 12'h435 && reg_wdata_i[0] |->
    ##2 !tracking_o) else $error("force did not stop tracking");
  chk_clear_on_start: assert property (
    $rose(tracking_o) |-> history_clear_o) else $error("no history clear");
  chk_accum_follows: assert property (
    history_accumulate_o == tracking_o) else $error("accumulate wrong");
  chk_wide_forced: assert property (
    fastlock_manual_i |=> wide_bandwidth_active_o) else $error("not wide");
  chk_wide_off: assert property (
    !fastlock_manual_i && !fastlock_auto_i |=> !wide_bandwidth_active_o)
    else $error("wide without fastlock");
  chk_hitless_write: assert property (
    reg_write_i && reg_addr_i == 12'h436 |=>
    hitless_enable_o == $past(reg_wdata_i[2])) else $error("hitless bit");
  chk_thresh_write: assert property (
    reg_write_i && reg_addr_i == 12'h43b |=>
    phase_measure_threshold_o[7:0] == $past(reg_wdata_i))
    else $error("threshold low byte");
  chk_length_write: assert property (
    reg_write_i && reg_addr_i == 12'h43d |=>
    coarse_measure_length_o == $past(reg_wdata_i[4:0]))
    else $error("coarse length");
endmodule

// ==== verif/pll_input_switch_holdover_ctrl_tb.sv ====
// Purpose: Self-checking bench of reference switch and holdover control.
// Assumes: Register strobes are one-cycle pulses driven at rising edges.
// Notes:   Outputs are sampled at falling edges, away from updates.
`timescale 1ns/10ps
module pll_input_switch_holdover_ctrl_tb;
  localparam [87:0] RST = 88'h00_00_00_21_43_01_00_00_00_00_00;
  localparam [87:0] MSK = 88'h01_07_ff_77_77_01_ff_03_1f_1f_00;
  reg        clk_i = 1'b0;
  reg        resetn_i = 1'b0;
  reg [11:0] reg_addr_i = 12'h000;
  reg [7:0]  reg_wdata_i = 8'h00;
  reg        reg_write_i = 1'b0;
  reg        reg_read_i = 1'b0;
  reg [1:0]  manual_select_i = 2'h0;
  reg        lock_lost_flag_i = 1'b0;
  reg        history_ready_i = 1'b0;
  reg        fastlock_manual_i = 1'b0;
  reg        fastlock_auto_i = 1'b0;
  reg [3:0]  lose_cmd = 4'h0;
  reg [3:0]  drift_cmd = 4'h0;
  reg [7:0]  rdv;
  integer    fail_count = 0;
  integer    checked = 0;
  integer    i;
  wire [3:0] signal_absent_fault_i;
  wire [3:0] frequency_offset_fault_i;
  wire [7:0] reg_rdata_o;
  wire       reg_rvalid_o;
  wire [1:0] selected_input_o;
  wire       tracking_o;
  wire       holdover_o;
  wire       freerun_o;
  wire       history_accumulate_o;
  wire       history_clear_o;
  wire       wide_bandwidth_active_o;
  wire       hitless_enable_o;
  wire [9:0] phase_measure_threshold_o;
  wire [4:0] coarse_measure_length_o;
  wire [4:0] coarse_measure_delay_o;
  wire [1:0] hitless_method_o;
  wire [1:0] phase_measure_ctrl_o;

  pll_input_switch_holdover_ctrl dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .signal_absent_fault_i(signal_absent_fault_i),
    .frequency_offset_fault_i(frequency_offset_fault_i),
    .manual_select_i(manual_select_i), .lock_lost_flag_i(lock_lost_flag_i),
    .history_ready_i(history_ready_i), .fastlock_manual_i(fastlock_manual_i),
    .fastlock_auto_i(fastlock_auto_i), .selected_input_o(selected_input_o),
    .tracking_o(tracking_o), .holdover_o(holdover_o), .freerun_o(freerun_o),
    .history_accumulate_o(history_accumulate_o),
    .history_clear_o(history_clear_o),
    .wide_bandwidth_active_o(wide_bandwidth_active_o),
    .hitless_enable_o(hitless_enable_o),
    .hitless_method_o(hitless_method_o),
    .phase_measure_ctrl_o(phase_measure_ctrl_o),
    .phase_measure_threshold_o(phase_measure_threshold_o),
    .coarse_measure_length_o(coarse_measure_length_o),
    .coarse_measure_delay_o(coarse_measure_delay_o)
  );

  ref_source_model src_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .lose_cmd_i(lose_cmd),
    .drift_cmd_i(drift_cmd), .signal_absent_fault_o(signal_absent_fault_i),
    .frequency_offset_fault_o(frequency_offset_fault_i)
  );

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task final_report;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task cmp_reg(input [11:0] a, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        $display("CHECK FAILED reg %h exp %h got %h", a, e, g);
        fail_count = fail_count + 1;
      end
    end
  endtask

  task cmp_out(input [39:0] nm, input [9:0] e, input [9:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        fail_count = fail_count + 1;
      end
    end
  endtask

  task wr(input [11:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
    end
  endtask

  task rc(input [11:0] a, input [7:0] e);
    integer n;
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      n = 0;
      @(negedge clk_i);
      while (reg_rvalid_o !== 1'b1 && n < 4) begin
        @(negedge clk_i);
        n = n + 1;
      end
      if (n == 4) begin
        $display("CHECK FAILED rvalid exp 1 got %b", reg_rvalid_o);
        fail_count = fail_count + 1;
        final_report;
      end
      rdv = reg_rdata_o;
      cmp_reg(a, e, rdv);
    end
  endtask

  task settle;
    begin
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
    end
  endtask

  task setf(input [3:0] l, input [3:0] d);
    begin
      @(posedge clk_i);
      lose_cmd  <= l;
      drift_cmd <= d;
      settle;
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (i = 0; i < 11; i = i + 1)
      rc(12'h435 + i[11:0], RST[87-8*i -: 8]);
    for (i = 0; i < 11; i = i + 1)
      wr(12'h435 + i[11:0], (i == 5) ? 8'h01 : 8'hff);
    for (i = 0; i < 11; i = i + 1)
      rc(12'h435 + i[11:0], MSK[87-8*i -: 8]);
    wr(12'h440, 8'hff);
    rc(12'h440, 8'h00);
    cmp_out("thr", 10'h3ff, phase_measure_threshold_o);
    cmp_out("len", 10'h01f, {5'h00, coarse_measure_length_o});
    cmp_out("dly", 10'h01f, {5'h00, coarse_measure_delay_o});
    cmp_out("hsw", 10'h001, {9'h000, hitless_enable_o});
    cmp_out("meth", 10'h001,
            {6'h00, phase_measure_ctrl_o, hitless_method_o});
    for (i = 0; i < 10; i = i + 1)
      wr(12'h435 + i[11:0], RST[87-8*i -: 8]);
    settle;
    cmp_out("hsw", 10'h000, {9'h000, hitless_enable_o});
    cmp_out("trk", 10'h001, {9'h000, tracking_o});
    // History gathered while tracking decides holdover against freerun.
    @(posedge clk_i);
    history_ready_i <= 1'b1;
    settle;
    rc(12'h43f, 8'h02);
    wr(12'h435, 8'h01);
    settle;
    cmp_out("hold", 10'h001, {9'h000, holdover_o});
    cmp_out("acc", 10'h000, {9'h000, history_accumulate_o});
    @(posedge clk_i);
    history_ready_i <= 1'b0;
    wr(12'h435, 8'h00);
    settle;
    rc(12'h43f, 8'h00);
    wr(12'h435, 8'h01);
    settle;
    cmp_out("free", 10'h001, {9'h000, freerun_o});
    wr(12'h435, 8'h00);
    wr(12'h436, 8'h02);
    setf(4'h1, 4'h0);
    cmp_out("sel", 10'h001, {8'h00, selected_input_o});
    wr(12'h437, 8'h01);
    settle;
    cmp_out("sel", 10'h000, {8'h00, selected_input_o});
    setf(4'h0, 4'h1);
    cmp_out("sel", 10'h001, {8'h00, selected_input_o});
    wr(12'h437, 8'h10);
    settle;
    cmp_out("sel", 10'h000, {8'h00, selected_input_o});
    wr(12'h437, 8'h00);
    wr(12'h436, 8'h01);
    setf(4'h0, 4'h0);
    cmp_out("sel", 10'h001, {8'h00, selected_input_o});
    wr(12'h438, 8'h22);
    wr(12'h439, 8'h22);
    wr(12'h436, 8'h02);
    settle;
    cmp_out("sel", 10'h000, {8'h00, selected_input_o});
    setf(4'h1, 4'h0);
    cmp_out("sel", 10'h001, {8'h00, selected_input_o});
    wr(12'h438, 8'h30);
    setf(4'h0, 4'h0);
    cmp_out("sel", 10'h002, {8'h00, selected_input_o});
    wr(12'h439, 8'h14);
    settle;
    cmp_out("sel", 10'h003, {8'h00, selected_input_o});
    @(posedge clk_i);
    history_ready_i <= 1'b1;
    setf(4'hf, 4'h0);
    cmp_out("hold", 10'h001, {9'h000, holdover_o});
    @(posedge clk_i);
    history_ready_i <= 1'b0;
    setf(4'h0, 4'h0);
    setf(4'hf, 4'h0);
    cmp_out("free", 10'h001, {9'h000, freerun_o});
    wr(12'h436, 8'h00);
    setf(4'h0, 4'h0);
    cmp_out("sel", 10'h000, {8'h00, selected_input_o});
    cmp_out("trk", 10'h001, {9'h000, tracking_o});
    @(posedge clk_i);
    fastlock_auto_i  <= 1'b1;
    lock_lost_flag_i <= 1'b1;
    manual_select_i  <= 2'h1;
    settle;
    cmp_out("sel", 10'h001, {8'h00, selected_input_o});
    rc(12'h43f, 8'h04);
    @(posedge clk_i);
    lock_lost_flag_i <= 1'b0;
    settle;
    rc(12'h43f, 8'h00);
    @(posedge clk_i);
    fastlock_manual_i <= 1'b1;
    settle;
    cmp_out("wide", 10'h001, {9'h000, wide_bandwidth_active_o});
    final_report;
  end
endmodule

bind pll_input_switch_holdover_ctrl pll_switch_chk chk_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .tracking_o(tracking_o),
  .holdover_o(holdover_o), .freerun_o(freerun_o),
  .history_accumulate_o(history_accumulate_o),
  .history_clear_o(history_clear_o),
  .wide_bandwidth_active_o(wide_bandwidth_active_o),
  .fastlock_manual_i(fastlock_manual_i), .fastlock_auto_i(fastlock_auto_i),
  .hitless_enable_o(hitless_enable_o),
  .phase_measure_threshold_o(phase_measure_threshold_o),
  .coarse_measure_length_o(coarse_measure_length_o)
);
